/* File: dv/i2c_master_model.sv */
// Behavioural bus master driving the clock and an open-drain data line
`timescale 1ns/100ps
module i2c_master_model
(
	input wire logic sda_line,
	output logic scl,
	output logic sda
);
	localparam int T_LOW = 5000;
	localparam int T_HIGH = 4000;
	// Released bus idles high through the pull-up
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Data falls while the clock is high
	task automatic start_cond();
		#500 sda = 1'b1;
		#T_LOW scl = 1'b1;
		#T_HIGH sda = 1'b0;
		#T_HIGH scl = 1'b0;
	endtask
	task automatic stop_cond();
		#500 sda = 1'b0;
		#T_LOW scl = 1'b1;
		#T_HIGH sda = 1'b1;
		#T_HIGH;
	endtask
	// Data moves well after the fall so it never looks like a start or stop
	task automatic send_byte(input logic [7:0] d, output logic acked);
		for (int i = 8; i >= 0; i--)
		begin
			#500 sda = (i == 0) ? 1'b1 : d[i-1];
			#T_LOW scl = 1'b1;
			#T_HIGH acked = !sda_line;
			scl = 1'b0;
		end
	endtask
	// Master as receiver: data line released, ack or nack given in the ninth slot
	task automatic recv_byte(output logic [7:0] d, input logic ack);
		for (int i = 8; i >= 0; i--)
		begin
			#500 sda = (i == 0) ? !ack : 1'b1;
			#T_LOW scl = 1'b1;
			#T_HIGH;
			if (i > 0)
				d[i-1] = sda_line;
			scl = 1'b0;
		end
	endtask
endmodule

/* File: dv/i2c_port_sva.sv */
// Assertion checker for the two-wire slave port
`timescale 1ns/100ps
module i2c_port_sva
	import i2c_port_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pin_route_select,
	input wire pin_in_type port_c_pins,
	input wire pin_out_type port_c_drive,
	input wire pin_out_type port_d_drive,
	input wire logic [7:0] port_control_reg,
	input wire logic buffer_read,
	input wire logic buffer_write,
	input wire logic overflow_clear,
	input wire logic [7:0] receive_transmit_buffer,
	input wire port_status_type port_status_reg,
	input wire logic receive_overflow_flag,
	input wire logic port_interrupt_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Open drain: the pin may only be pulled low
	drain_only_a: assert property (port_c_drive.sda_oe |-> !port_c_drive.sda_out)
		else $error("data pin driven high");
	// Unrouted port stays quiet once the route has settled
	route_a: assert property ($stable(pin_route_select) |->
		!(pin_route_select ? port_d_drive.sda_oe : port_c_drive.sda_oe))
		else $error("unrouted port drives");
	// Disabled port neither drives nor flags
	idle_off_a: assert property (!port_control_reg[5] && !$past(port_control_reg[5]) |->
		!port_c_drive.sda_oe && !port_d_drive.sda_oe && !$rose(port_interrupt_flag))
		else $error("disabled port active");
	// Drive changes in the low phase, so the master never sees a glitch
	ack_phase_a: assert property ($changed(port_c_drive.sda_oe) |-> !$past(port_c_pins.scl))
		else $error("drive changed with clock high");
	full_clear_a: assert property ($fell(port_status_reg.buffer_full_flag) |-> $past(buffer_read))
		else $error("full flag fell unread");
	over_sticky_a: assert property ($fell(receive_overflow_flag) |-> $past(overflow_clear))
		else $error("overflow cleared by itself");
	refuse_keep_a: assert property ($rose(receive_overflow_flag) |->
		$stable(receive_transmit_buffer) ##[0:1] port_interrupt_flag)
		else $error("refused byte altered buffer");
	full_irq_a: assert property ($rose(port_status_reg.buffer_full_flag) && !$past(buffer_write) |->
		port_interrupt_flag)
		else $error("byte stored without flag");
endmodule
bind i2c_slave_serial_port i2c_port_sva i2c_port_sva_inst (.clk, .sys_rst, .pin_route_select,
	.port_c_pins, .port_c_drive, .port_d_drive, .port_control_reg, .buffer_read,
	.buffer_write, .overflow_clear, .receive_transmit_buffer, .port_status_reg,
	.receive_overflow_flag, .port_interrupt_flag);

/* File: dv/tb_i2c_slave_serial_port.sv */
// Self-checking bench for the two-wire slave port
`timescale 1ns/100ps
`include "i2c_port_defs.svh"
module tb_i2c_slave_serial_port
	import i2c_port_pkg::*;
;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic pin_route_select = 1'b1;
	logic [7:0] port_c_direction = 8'hff;
	logic [7:0] port_d_direction = 8'hff;
	logic [7:0] port_control_reg = 8'h00;
	logic [9:0] own_address_reg = 10'h2a5;
	logic buffer_read = 1'b0;
	logic buffer_write = 1'b0;
	logic [7:0] buffer_wdata = 8'h00;
	logic overflow_clear = 1'b0;
	logic interrupt_clear = 1'b0;
	logic scl, sda, sda_line, acked, receive_overflow_flag, port_interrupt_flag;
	logic [7:0] wa, receive_transmit_buffer;
	pin_in_type port_c_pins, port_d_pins;
	pin_out_type port_c_drive, port_d_drive;
	port_status_type port_status_reg;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	// Wired-AND data line; the unrouted port sees an idle bus
	assign sda_line = sda & !(pin_route_select ? port_c_drive.sda_oe : port_d_drive.sda_oe);
	assign port_c_pins = pin_route_select ? pin_in_type'({scl, sda_line}) : pin_in_type'(2'b11);
	assign port_d_pins = pin_route_select ? pin_in_type'(2'b11) : pin_in_type'({scl, sda_line});
	assign wa = {own_address_reg[6:0], 1'b0};
	i2c_slave_serial_port i2c_slave_serial_port_inst (.clk, .sys_rst, .scl_link_clk(scl),
		.pin_route_select, .port_c_direction, .port_d_direction, .port_c_pins, .port_d_pins,
		.port_c_drive, .port_d_drive, .port_control_reg, .own_address_reg, .buffer_read,
		.buffer_write, .buffer_wdata, .overflow_clear, .interrupt_clear,
		.receive_transmit_buffer, .port_status_reg, .receive_overflow_flag, .port_interrupt_flag);
	i2c_master_model i2c_master_model_inst (.sda_line, .scl, .sda);
	initial
	begin
		forever #50 clk = ~clk;
	end
	// Hang guard, about twice the expected run
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic pulse(ref logic s);
		@(posedge clk);
		#10 s = 1'b1;
		@(posedge clk);
		#10 s = 1'b0;
	endtask
	task automatic go();
		i2c_master_model_inst.start_cond();
	endtask
	task automatic halt();
		i2c_master_model_inst.stop_cond();
	endtask
	task automatic tx(input logic [7:0] d, input logic ack);
		i2c_master_model_inst.send_byte(d, acked);
		check(acked, ack);
	endtask
	// Everything but the enable bit set up
	task automatic s_off();
		check(receive_transmit_buffer, 8'h00);
		port_control_reg = {4'h0, `MODE_SLAVE7_SS};
		go();
		tx(wa, 1'b0);
		halt();
		check(port_interrupt_flag, 1'b0);
		check(port_status_reg, 8'h00);
	endtask
	// Each mode once, alternating the pin route
	task automatic s_modes();
		logic [3:0] md [5] = '{`MODE_SLAVE7, `MODE_SLAVE10, `MODE_SLAVE7_SS, `MODE_SLAVE10_SS,
			`MODE_SS_IDLE};
		logic [7:0] first;
		logic slave;
		for (int i = 0; i < 5; i++)
		begin
			slave = md[i] != `MODE_SS_IDLE;
			first = md[i][0] ? {`TEN_BIT_HEADER, own_address_reg[9:8], 1'b0} : wa;
			@(posedge clk);
			#10 port_control_reg = {4'h2, md[i]};
			pin_route_select = i[0];
			pulse(interrupt_clear);
			go();
			#2000 check(port_interrupt_flag, md[i][3]);
			tx(first, slave);
			if (slave)
				check(receive_transmit_buffer, first);
			pulse(buffer_read);
			if (slave && md[i][0])
			begin
				tx(own_address_reg[7:0], 1'b1);
				pulse(buffer_read);
			end
			if (slave)
			begin
				tx(8'h3c, 1'b1);
				check(receive_transmit_buffer, 8'h3c);
				check(port_status_reg.data_not_addr, 1'b1);
				pulse(buffer_read);
			end
			halt();
			check(port_status_reg.stop_seen, 1'b1);
		end
	endtask
	// Full buffer, then overflow, then recovery by software
	task automatic s_refuse();
		@(posedge clk);
		#10 port_control_reg = {4'h2, `MODE_SLAVE7};
		pin_route_select = 1'b1;
		go();
		tx(wa, 1'b1);
		pulse(buffer_read);
		check(port_status_reg.buffer_full_flag, 1'b0);
		tx(8'h3c, 1'b1);
		pulse(interrupt_clear);
		tx(8'h55, 1'b0);
		check(receive_transmit_buffer, 8'h3c);
		check(port_interrupt_flag, 1'b1);
		check(receive_overflow_flag, 1'b1);
		pulse(buffer_read);
		tx(8'h66, 1'b0);
		check(receive_transmit_buffer, 8'h3c);
		halt();
		pulse(overflow_clear);
		check(receive_overflow_flag, 1'b0);
		go();
		tx(wa, 1'b1);
		halt();
		pulse(buffer_read);
	endtask
	// General call, a pin set as output, software buffer load
	task automatic s_misc();
		own_address_reg = 10'h000;
		go();
		tx(8'h00, 1'b0);
		halt();
		own_address_reg = 10'h2a5;
		port_c_direction = 8'hef;
		go();
		tx(wa, 1'b0);
		halt();
		port_c_direction = 8'hff;
		buffer_wdata = 8'h96;
		pulse(buffer_write);
		check(receive_transmit_buffer, 8'h96);
	endtask
	// Slave-transmitter: two bytes loaded by software, master nacks the last
	task automatic s_read();
		logic [7:0] got;
		pulse(buffer_read);
		buffer_wdata = 8'hc3;
		pulse(buffer_write);
		go();
		tx(wa | 8'h01, 1'b1);
		check(receive_transmit_buffer, wa | 8'h01);
		check(port_status_reg.read_not_write, 1'b1);
		buffer_wdata = 8'h5a;
		pulse(buffer_write);
		i2c_master_model_inst.recv_byte(got, 1'b1);
		check(got, 8'hc3);
		i2c_master_model_inst.recv_byte(got, 1'b0);
		check(got, 8'h5a);
		halt();
		check(port_status_reg.start_seen, 1'b0);
		pulse(buffer_read);
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		#10 sys_rst = 1'b0;
		repeat (4) @(posedge clk);
		#10;
		s_off();
		s_modes();
		s_refuse();
		s_misc();
		s_read();
		wrap_up();
	end
endmodule

/* File: hdl/gray_sync.sv */
`timescale 1ns/100ps
// Three-stage synchroniser for a gray-coded pointer from the link clock
module gray_sync
	import i2c_port_pkg::*;
#(
	parameter int WIDTH = 4
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] gray_in,
	output logic [WIDTH-1:0] gray_out
);
	logic [WIDTH-1:0] stage1, stage2, stage3, next_out;

	// One bit moves per step, so a word that agrees twice is a real pointer value
	always_comb
	begin
		next_out = sys_rst ? '0 : ((stage2 == stage3) ? stage3 : gray_out);
	end

	// Stage one feeds only stage two; only the filtered output is reset
	always_ff @(posedge clk)
	begin
		stage1 <= gray_in;
		stage2 <= stage1;
		stage3 <= stage2;
		gray_out <= next_out;
	end
endmodule

/* File: hdl/i2c_port_defs.svh */
// Constants for the two-wire slave port: field positions, mode codes, pointer sizes
`ifndef I2C_PORT_DEFS_SVH
`define I2C_PORT_DEFS_SVH
`define CTRL_MODE_HI 3
`define CTRL_MODE_LO 0
`define CTRL_ENABLE_BIT 5
`define MODE_SLAVE7 4'h6
`define MODE_SLAVE10 4'h7
`define MODE_SLAVE7_SS 4'he
`define MODE_SLAVE10_SS 4'hf
`define MODE_SS_IDLE 4'hb
`define TEN_BIT_HEADER 5'h1e
`define GENERAL_CALL 7'h00
`define BITS_PER_BYTE 4'h8
`define PTR_W 4
`endif

/* File: hdl/i2c_port_pkg.sv */
// Types shared by the two-wire slave port
package i2c_port_pkg;
	typedef struct packed {
		logic scl;
		logic sda;
	} pin_in_type;
	typedef struct packed {
		logic scl_out;
		logic scl_oe;
		logic sda_out;
		logic sda_oe;
		logic sdo_out;
		logic sdo_oe;
	} pin_out_type;
	typedef struct packed {
		logic start_seen;
		logic stop_seen;
		logic data_not_addr;
		logic read_not_write;
		logic buffer_full_flag;
	} port_status_type;
	typedef enum logic [2:0] {st_idle, st_addr, st_addr_low, st_rx, st_tx, st_skip} state_type;
endpackage

/* File: hdl/i2c_slave_serial_port.sv */
`timescale 1ns/100ps
// Two-wire slave serial port: bit capture on the link clock, protocol on the system clock
`include "i2c_port_defs.svh"
// Functional notes
// - All slave functions work, but the all-zero general call address is never matched.
// - Start and stop conditions are detected; they raise the port interrupt flag only in the three start/stop modes.
// - Standard-mode timing; seven-bit and ten-bit slave addressing both supported.
// - Nothing on the bus works until the enable bit, control bit 5, is set.
// - Four-bit mode field selects one of five slave or start/stop modes.
// - Pins drive only open-drain, and only when both direction bits say input.
// - Route bit high uses port C pins 5,4,7; low uses port D 3,2,1.
// - As slave-transmitter the port drives its own data onto the data pin.
// - Matched address or data byte: shifted byte goes to buffer, then is acknowledged in the ack slot.
// - No acknowledge when buffer-full or overflow was already set before the byte.
// - Refused byte leaves buffer unchanged but still sets the port interrupt flag.
// - Reading the buffer clears the buffer-full flag.
// - The shift register has no address; software only sees the buffer.
module i2c_slave_serial_port
	import i2c_port_pkg::*;
#(
	parameter int RING_DEPTH = 8
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_link_clk,
	input wire logic pin_route_select,
	input wire logic [7:0] port_c_direction,
	input wire logic [7:0] port_d_direction,
	input wire pin_in_type port_c_pins,
	input wire pin_in_type port_d_pins,
	output pin_out_type port_c_drive,
	output pin_out_type port_d_drive,
	input wire logic [7:0] port_control_reg,
	input wire logic [9:0] own_address_reg,
	input wire logic buffer_read,
	input wire logic buffer_write,
	input wire logic [7:0] buffer_wdata,
	input wire logic overflow_clear,
	input wire logic interrupt_clear,
	output logic [7:0] receive_transmit_buffer,
	output port_status_type port_status_reg,
	output logic receive_overflow_flag,
	output logic port_interrupt_flag
);
	// Link domain: each rising link clock writes one data bit into a small ring
	logic ring [RING_DEPTH];
	logic [`PTR_W-1:0] wr_bin = '0;
	logic [`PTR_W-1:0] wr_gray = '0;
	logic [`PTR_W-1:0] next_wr_bin;
	logic link_sda;

	// Raw data pin is sampled by the link clock itself, the way the bus defines it
	always_comb
	begin
		link_sda = pin_route_select ? port_c_pins.sda : port_d_pins.sda;
		next_wr_bin = wr_bin + `PTR_W'(1);
	end

	always_ff @(posedge scl_link_clk)
	begin
		ring[wr_bin[`PTR_W-2:0]] <= link_sda;
		wr_bin <= next_wr_bin;
		wr_gray <= next_wr_bin ^ (next_wr_bin >> 1);
	end

	function automatic logic [`PTR_W-1:0] gray_to_bin(input logic [`PTR_W-1:0] g);
		logic [`PTR_W-1:0] b;
		b[`PTR_W-1] = g[`PTR_W-1];
		for (int k = `PTR_W - 2; k >= 0; k--)
			b[k] = b[k+1] ^ g[k];
		return b;
	endfunction

	// Seven-bit compare with the general call excluded
	function automatic logic addr7_hit(input logic [6:0] rx, input logic [9:0] own);
		return (rx == own[6:0]) && (rx != `GENERAL_CALL);
	endfunction

	logic [`PTR_W-1:0] wr_gray_sys;
	logic [3:0] pins_sync;
	logic scl_c, sda_c, scl_d, sda_d;

	// Pointer path has as many stages as the pin path, so a bit is handled
	// only once the synced clock is high and the data drive cannot move early
	gray_sync #(.WIDTH(`PTR_W)) u_ptr_sync
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.gray_in(wr_gray),
		.gray_out(wr_gray_sys)
	);

	pin_sync #(.WIDTH(4)) u_pin_sync
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in({port_c_pins.scl, port_c_pins.sda, port_d_pins.scl, port_d_pins.sda}),
		.sync_out(pins_sync)
	);

	assign {scl_c, sda_c, scl_d, sda_d} = pins_sync;

	// System domain state
	state_type state, next_state;
	logic [`PTR_W-1:0] rd_bin, next_rd_bin;
	logic [7:0] serial_shift_reg, next_shift;
	logic [7:0] tx_shift, next_tx_shift;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic scl_prev, sda_prev, next_scl_prev, next_sda_prev;
	logic give_ack, next_give_ack;
	logic ten_bit_done, next_ten_bit_done;
	logic sda_drive, next_sda_drive;
	logic [7:0] next_buffer;
	port_status_type next_status;
	logic next_ovf, next_pif;
	pin_out_type next_c_drive, next_d_drive;

	logic scl_now, sda_now, enabled, ten_bit_mode, ss_irq, slave_on, dir_ok;
	logic start_evt, stop_evt, bit_avail, bit_val, byte_done, refuse;
	logic [7:0] rx;
	logic hit;
	logic [3:0] mode;

	// Decode of mode field, routing and bus conditions
	always_comb
	begin
		mode = port_control_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
		enabled = port_control_reg[`CTRL_ENABLE_BIT];
		ten_bit_mode = (mode == `MODE_SLAVE10) || (mode == `MODE_SLAVE10_SS);
		ss_irq = (mode == `MODE_SLAVE7_SS) || (mode == `MODE_SLAVE10_SS) ||
			(mode == `MODE_SS_IDLE);
		slave_on = enabled && ((mode == `MODE_SLAVE7) || (mode == `MODE_SLAVE7_SS) ||
			ten_bit_mode);
		scl_now = pin_route_select ? scl_c : scl_d;
		sda_now = pin_route_select ? sda_c : sda_d;
		dir_ok = pin_route_select ? (port_c_direction[5] && port_c_direction[4]) :
			(port_d_direction[3] && port_d_direction[2]);
		start_evt = enabled && scl_now && scl_prev && sda_prev && !sda_now;
		stop_evt = enabled && scl_now && scl_prev && !sda_prev && sda_now;
		bit_avail = (gray_to_bin(wr_gray_sys) != rd_bin);
		bit_val = ring[rd_bin[`PTR_W-2:0]];
		byte_done = bit_avail && (bit_cnt == `BITS_PER_BYTE - 4'h1);
		refuse = port_status_reg.buffer_full_flag || receive_overflow_flag;
	end

	// Protocol engine: one bit handled per ring entry, bytes of eight plus ack slot
	always_comb
	begin
		rx = {serial_shift_reg[6:0], bit_val}; // Byte candidate with the incoming bit
		hit = 1'b0;
		next_state = state;
		next_rd_bin = rd_bin;
		next_shift = serial_shift_reg;
		next_tx_shift = tx_shift;
		next_bit_cnt = bit_cnt;
		next_give_ack = give_ack;
		next_ten_bit_done = ten_bit_done;
		next_buffer = receive_transmit_buffer;
		next_status = port_status_reg;
		next_ovf = receive_overflow_flag && !overflow_clear;
		next_pif = port_interrupt_flag && !interrupt_clear;
		next_scl_prev = scl_now;
		next_sda_prev = sda_now;
		if (buffer_read)
			next_status.buffer_full_flag = 1'b0;
		if (buffer_write)
			next_buffer = buffer_wdata;
		if (bit_avail)
		begin
			next_rd_bin = rd_bin + `PTR_W'(1);
			if (bit_cnt == `BITS_PER_BYTE)
			begin
				// Ack slot: master nack ends a read, otherwise reload the next byte
				next_bit_cnt = 4'h0;
				next_give_ack = 1'b0;
				if (state == st_tx)
				begin
					// The address slot keeps the byte loaded at match; only data slots reload
					if (bit_val)
						next_state = st_skip;
					else if (!give_ack)
						next_tx_shift = receive_transmit_buffer;
				end
			end
			else
			begin
				next_shift = {serial_shift_reg[6:0], bit_val};
				next_bit_cnt = bit_cnt + 4'h1;
				if (state == st_tx)
					next_tx_shift = {tx_shift[6:0], 1'b1};
			end
		end
		if (byte_done && state != st_tx && state != st_idle && state != st_skip)
		begin
			// Full byte assembled from the shift value plus the incoming bit
			case (state)
				st_addr:
					if (ten_bit_mode)
						hit = (rx[7:3] == `TEN_BIT_HEADER) && (rx[2:1] == own_address_reg[9:8]) &&
							(!rx[0] || ten_bit_done);
					else
						hit = addr7_hit(rx[7:1], own_address_reg);
				st_addr_low:
					hit = (rx == own_address_reg[7:0]);
				st_rx:
					hit = 1'b1;
				default:
					hit = 1'b0;
			endcase
			if (!hit)
				next_state = st_skip;
			else
			begin
				next_pif = 1'b1;
				next_status.data_not_addr = (state == st_rx);
				if (state == st_addr)
					next_status.read_not_write = rx[0];
				if (refuse)
				begin
					next_ovf = next_ovf || port_status_reg.buffer_full_flag;
					next_state = (state == st_rx) ? st_rx : st_skip;
				end
				else
				begin
					next_give_ack = 1'b1;
					next_buffer = rx;
					next_status.buffer_full_flag = 1'b1;
					if (state == st_addr && rx[0])
					begin
						next_state = st_tx;
						next_tx_shift = buffer_write ? buffer_wdata : receive_transmit_buffer;
					end
					else if (state == st_addr && ten_bit_mode)
						next_state = st_addr_low;
					else
					begin
						next_state = st_rx;
						next_ten_bit_done = next_ten_bit_done || (state == st_addr_low);
					end
				end
			end
		end
		if (start_evt)
		begin
			// Start or repeated start: drop stale bits and look for an address
			next_state = slave_on ? st_addr : st_idle;
			next_rd_bin = gray_to_bin(wr_gray_sys);
			next_bit_cnt = 4'h0;
			next_give_ack = 1'b0;
			next_status.start_seen = 1'b1;
			next_status.stop_seen = 1'b0;
			next_pif = next_pif || ss_irq;
		end
		if (stop_evt)
		begin
			next_state = st_idle;
			next_ten_bit_done = 1'b0;
			next_give_ack = 1'b0;
			next_status.stop_seen = 1'b1;
			next_status.start_seen = 1'b0;
			next_pif = next_pif || ss_irq;
		end
		if (!enabled)
		begin
			next_state = st_idle;
			next_ten_bit_done = 1'b0;
			next_give_ack = 1'b0;
			next_rd_bin = gray_to_bin(wr_gray_sys);
		end
	end

	// Data line changes only while the clock is low, except the release on disable, start or stop, which ignores the clock
	always_comb
	begin
		next_sda_drive = sda_drive;
		if (!scl_now)
		begin
			if (bit_cnt == `BITS_PER_BYTE)
				next_sda_drive = give_ack;
			else if (state == st_tx)
				next_sda_drive = !tx_shift[7];
			else
				next_sda_drive = 1'b0;
		end
		if (!enabled || stop_evt || start_evt)
			next_sda_drive = 1'b0;
		next_c_drive = '0;
		next_d_drive = '0;
		next_c_drive.sda_oe = sda_drive && enabled && pin_route_select && dir_ok;
		next_d_drive.sda_oe = sda_drive && enabled && !pin_route_select && dir_ok;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= st_idle;
			rd_bin <= '0;
			serial_shift_reg <= 8'h00;
			tx_shift <= 8'hff;
			bit_cnt <= 4'h0;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			give_ack <= 1'b0;
			ten_bit_done <= 1'b0;
			sda_drive <= 1'b0;
			receive_transmit_buffer <= 8'h00;
			port_status_reg <= '0;
			receive_overflow_flag <= 1'b0;
			port_interrupt_flag <= 1'b0;
			port_c_drive <= '0;
			port_d_drive <= '0;
		end
		else
		begin
			state <= next_state;
			rd_bin <= next_rd_bin;
			serial_shift_reg <= next_shift;
			tx_shift <= next_tx_shift;
			bit_cnt <= next_bit_cnt;
			scl_prev <= next_scl_prev;
			sda_prev <= next_sda_prev;
			give_ack <= next_give_ack;
			ten_bit_done <= next_ten_bit_done;
			sda_drive <= next_sda_drive;
			receive_transmit_buffer <= next_buffer;
			port_status_reg <= next_status;
			receive_overflow_flag <= next_ovf;
			port_interrupt_flag <= next_pif;
			port_c_drive <= next_c_drive;
			port_d_drive <= next_d_drive;
		end
	end
endmodule

/* File: hdl/pin_sync.sv */
`timescale 1ns/100ps
// Three-stage input synchroniser that passes a change once stages two and three agree
module pin_sync
	import i2c_port_pkg::*;
#(
	parameter int WIDTH = 4
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1, stage2, stage3, next_out;

	// Stage one feeds only stage two; filter compares stages two and three
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_comb
			begin
				next_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		stage1 <= async_in;
		stage2 <= stage1;
		stage3 <= stage2;
		if (sys_rst)
			sync_out <= {WIDTH{1'b1}};
		else
			sync_out <= next_out;
	end
endmodule
